/* overvoltage_latched_flag_consts.vh */
// Purpose: shared constants of the boost setpoint and overvoltage block
// Assumes: 50 MHz mclk, 8-bit ADC codes at 70/255 V per count
// Notes:   register indices, field positions, reset values, scaling
`ifndef OVERVOLTAGE_LATCHED_FLAG_CONSTS_VH
`define OVERVOLTAGE_LATCHED_FLAG_CONSTS_VH

// ****************************************************************
// register map (word index on the plain port)
// ****************************************************************
`define REG_CTRL        4'h0
`define REG_TARGET      4'h1
`define REG_OVCFG       4'h2
`define REG_FORCED      4'h3
`define REG_STATUS      4'h4
`define REG_LED1_ON     4'h5
`define REG_LED1        4'h6
`define REG_LED2_ON     4'h7
`define REG_LED2        4'h8
`define REG_BOOST_ADC   4'h9
`define REG_IRQ_STAT    4'ha
`define REG_IRQ_MASK    4'hb

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_EN_BIT     0
`define OVCFG_SD_LSB    0
`define OVCFG_RE_LSB    4
`define STAT_OV_BIT     0
`define STAT_RUN_BIT    1
`define PARITY_BIT      8
`define TARGET_RST      7'h00
`define OV_FLAG_RST     1'b1
`define LED_RES_RST     9'h100
`define IRQ_OV          0
`define IRQ_LED1        1
`define IRQ_LED2        2
`define IRQ_FORCED      3

// ****************************************************************
// ADC channel select codes
// ****************************************************************
`define ADC_BOOST       2'h0
`define ADC_LED1        2'h1
`define ADC_LED2        2'h2

// ****************************************************************
// scaling of target and margins into ADC counts
// ****************************************************************
`define TGT_BASE        9'h028
`define TGT_SLOPE       8'h62
`define TGT_SHIFT       6
`define SD_STEP         9'h004
`define RE_STEP         9'h004

`endif

/* boost_setpoint_ov_protect.v */
// Purpose: boost target, overvoltage gate suppression, LED voltage results
// Assumes: inputs synchronous to mclk; ADC delivers one code per adcValid
// Notes:   registers on a plain port, read data one cycle after the strobe
// Function
// - store each LED pin code (0.274 V/count) in the general result, and in on-voltage only while lit
// - every LED result carries odd parity in bit 8 over bits 7:0
// - with constant LED control input, force the measurement at the forced rate
// - forced period is interval setting times one ADC sequence; zero disables
// - 7-bit target, code zero is 11 V, top code about 64.2 V
// - after reset booster disabled and target code zero
// - with enable low the gate output stays inactive
// - above target plus shutdown margin, gate off at least this PWM cycle
// - a trip latches the overvoltage flag and clears the running flag
// - PWM stays suppressed until voltage below shutdown minus hysteresis
// - running returns on reactivation; flag clears on read in that state
// - comparison and flag logic work while the booster is disabled
// - too-low feedback also sets the flag and stops the booster
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "overvoltage_latched_flag_consts.vh"
`default_nettype none

module boost_setpoint_ov_protect
#(
  parameter LOW_FB_GUARD = 1
)
(
  input  wire        mclk,
  input  wire        arst_n,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wrStb,
  input  wire        rdStb,
  output reg  [15:0] rdata,
  input  wire        adcValid,
  input  wire [1:0]  adcSel,
  input  wire [7:0]  adcCode,
  input  wire        adcSeqDone,
  input  wire [1:0]  ledChannelControlInput,
  input  wire        boostFeedbackLow,
  input  wire        pwmRaw,
  output reg         gateOut,
  output reg  [1:0]  measReq,
  output wire        irq
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // odd parity word: bit 8 makes the count of ones odd
  function [8:0] withParity;
    input [7:0] v;
    begin
      withParity = {~(^v), v};
    end
  endfunction

  // margin or hysteresis steps in ADC counts; both thresholds share the scale
  function [9:0] stepCounts;
    input [8:0] step;
    input [2:0] n;
    begin
      stepCounts = {1'b0, step} * {7'h00, n};
    end
  endfunction

  // forced cadence due at this sequence end; counter restarts after a hit
  function forcedDue;
    input [8:0] count;
    input [8:0] interval;
    begin
      forcedDue = (count + 9'h001) >= interval;
    end
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  reg        boostEn;
  reg [6:0]  boostTargetCode;
  reg [2:0]  overvoltageShutdownMargin;
  reg [1:0]  overvoltageReactivationHysteresis;
  reg [8:0]  forcedMeasureInterval;
  reg        overvoltageLatchedFlag;
  reg        suppress;
  reg        gateBlock;
  reg        pwmPrev;
  reg [7:0]  boostOutputVoltage;
  reg [8:0]  ledOnVoltageResult1;
  reg [8:0]  ledStringVoltageResult1;
  reg [8:0]  ledOnVoltageResult2;
  reg [8:0]  ledStringVoltageResult2;
  reg [3:0]  irqStatus;
  reg [3:0]  irqMask;
  reg [1:0]  ctrlPrev;
  reg [8:0]  seqCount0;
  reg [8:0]  seqCount1;

  wire [13:0] slopeProd;
  wire [9:0]  targetCounts;
  wire [9:0]  shutdownLevel;
  wire [9:0]  reactLevel;
  wire [9:0]  boostWide;
  wire        overTrip;
  wire        lowTrip;
  wire        tripEvent;
  wire        reactOk;
  wire        statusRead;
  wire        ledEvt1;
  wire        ledEvt2;
  wire [1:0]  forcedHit;
  wire [1:0]  fallEdge;
  wire [1:0]  ctrlStable;
  wire        forcedOn;
  wire [3:0]  irqSet;

  // ****************************************************************
  // threshold arithmetic in ADC counts
  // ****************************************************************
  // target code mapped from 11 V base plus linear slope
  assign slopeProd = {7'h00, boostTargetCode} * {6'h00, `TGT_SLOPE};
  assign targetCounts = {1'b0, `TGT_BASE} + {2'b00, slopeProd[13:`TGT_SHIFT]};
  assign shutdownLevel = targetCounts
    + stepCounts(`SD_STEP, overvoltageShutdownMargin);
  assign reactLevel = shutdownLevel
    - stepCounts(`RE_STEP, {1'b0, overvoltageReactivationHysteresis});
  assign boostWide = {2'b00, boostOutputVoltage};

  // comparators run regardless of the enable bit
  assign overTrip = boostWide > shutdownLevel;
  assign lowTrip = (LOW_FB_GUARD != 0) && boostFeedbackLow;
  assign tripEvent = overTrip || lowTrip;
  assign reactOk = (boostWide < reactLevel) && !lowTrip;
  assign statusRead = rdStb && (addr == `REG_STATUS);

  // ****************************************************************
  // configuration writes
  // ****************************************************************
  // booster off and minimum target out of reset
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boostEn <= 1'b0;
      boostTargetCode <= `TARGET_RST;
      overvoltageShutdownMargin <= 3'h0;
      overvoltageReactivationHysteresis <= 2'h0;
      forcedMeasureInterval <= 9'h000;
      irqMask <= 4'h0;
    end
    else if (wrStb)
    begin
      case (addr)
        `REG_CTRL:     boostEn <= wdata[`CTRL_EN_BIT];
        `REG_TARGET:   boostTargetCode <= wdata[6:0];
        `REG_OVCFG:
        begin
          overvoltageShutdownMargin <= wdata[`OVCFG_SD_LSB +: 3];
          overvoltageReactivationHysteresis <= wdata[`OVCFG_RE_LSB +: 2];
        end
        `REG_FORCED:   forcedMeasureInterval <= wdata[8:0];
        `REG_IRQ_MASK: irqMask <= wdata[3:0];
        default:       boostEn <= boostEn;
      endcase
    end
  end

  // ****************************************************************
  // overvoltage suppression and latched flag
  // ****************************************************************
  // suppression kept apart from the software flag
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      suppress <= 1'b0;
    else if (tripEvent)
      suppress <= 1'b1;
    else if (suppress && reactOk)
      suppress <= 1'b0;
  end

  // flag starts set, so the first read may show it
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      overvoltageLatchedFlag <= `OV_FLAG_RST;
    else if (tripEvent)
      overvoltageLatchedFlag <= 1'b1;
    else if (statusRead && !suppress)
      overvoltageLatchedFlag <= 1'b0;
  end

  // ****************************************************************
  // gate drive
  // ****************************************************************
  // block holds until the next PWM rising edge after reactivation, so a
  // quick voltage drop cannot re-open the gate inside the tripped cycle
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gateBlock <= 1'b1;
      pwmPrev <= 1'b0;
      gateOut <= 1'b0;
    end
    else
    begin
      pwmPrev <= pwmRaw;
      if (tripEvent || suppress)
        gateBlock <= 1'b1;
      else if (pwmRaw && !pwmPrev)
        gateBlock <= 1'b0;
      gateOut <= pwmRaw && boostEn && !gateBlock && !tripEvent;
    end
  end

  // ****************************************************************
  // ADC result capture
  // ****************************************************************
  // any LED conversion is an interrupt event, lit or not
  assign ledEvt1 = adcValid && (adcSel == `ADC_LED1);
  assign ledEvt2 = adcValid && (adcSel == `ADC_LED2);

  // on-voltage refreshed only while the channel control is high
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boostOutputVoltage <= 8'h00;
      ledOnVoltageResult1 <= `LED_RES_RST;
      ledStringVoltageResult1 <= `LED_RES_RST;
      ledOnVoltageResult2 <= `LED_RES_RST;
      ledStringVoltageResult2 <= `LED_RES_RST;
    end
    else if (adcValid)
    begin
      case (adcSel)
        `ADC_BOOST: boostOutputVoltage <= adcCode;
        `ADC_LED1:
        begin
          ledStringVoltageResult1 <= withParity(adcCode);
          if (ledChannelControlInput[0])
            ledOnVoltageResult1 <= withParity(adcCode);
        end
        `ADC_LED2:
        begin
          ledStringVoltageResult2 <= withParity(adcCode);
          if (ledChannelControlInput[1])
            ledOnVoltageResult2 <= withParity(adcCode);
        end
        default: boostOutputVoltage <= boostOutputVoltage;
      endcase
    end
  end

  // ****************************************************************
  // measurement requests: falling edge or forced cadence
  // ****************************************************************
  assign forcedOn = forcedMeasureInterval != 9'h000;
  assign fallEdge = ctrlPrev & ~ledChannelControlInput;
  assign ctrlStable = ~(ctrlPrev ^ ledChannelControlInput);
  // a control change in between restarts the count, so dimming forces only when one control level outlasts the interval
  assign forcedHit[0] = forcedOn && adcSeqDone && ctrlStable[0]
    && forcedDue(seqCount0, forcedMeasureInterval);
  assign forcedHit[1] = forcedOn && adcSeqDone && ctrlStable[1]
    && forcedDue(seqCount1, forcedMeasureInterval);

  // each sequence counter restarts on a change of its own channel control
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrlPrev <= 2'b00;
      seqCount0 <= 9'h000;
      seqCount1 <= 9'h000;
      measReq <= 2'b00;
    end
    else
    begin
      ctrlPrev <= ledChannelControlInput;
      measReq <= fallEdge | forcedHit;
      if (!ctrlStable[0] || forcedHit[0] || !forcedOn)
        seqCount0 <= 9'h000;
      else if (adcSeqDone)
        seqCount0 <= seqCount0 + 9'h001;
      if (!ctrlStable[1] || forcedHit[1] || !forcedOn)
        seqCount1 <= 9'h000;
      else if (adcSeqDone)
        seqCount1 <= seqCount1 + 9'h001;
    end
  end

  // ****************************************************************
  // interrupt status, write one to clear, set wins
  // ****************************************************************
  // event bits in the order trip, LED1, LED2, forced
  assign irqSet = {(|forcedHit), ledEvt2, ledEvt1, tripEvent};

  // set beats a same-cycle clear so no event is lost
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      irqStatus <= 4'h0;
    else if (wrStb && (addr == `REG_IRQ_STAT))
      irqStatus <= (irqStatus & ~wdata[3:0]) | irqSet;
    else
      irqStatus <= irqStatus | irqSet;
  end

  // level output, drops once the last unmasked bit is cleared
  assign irq = |(irqStatus & irqMask);

  // ****************************************************************
  // read port, data one cycle after the strobe
  // ****************************************************************
  // unmapped addresses and idle cycles read zero
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= 16'h0000;
    else if (rdStb)
    begin
      case (addr)
        `REG_CTRL:      rdata <= {15'h0000, boostEn};
        `REG_TARGET:    rdata <= {9'h000, boostTargetCode};
        `REG_OVCFG:     rdata <= {10'h000, overvoltageReactivationHysteresis,
                                  1'b0, overvoltageShutdownMargin};
        `REG_FORCED:    rdata <= {7'h00, forcedMeasureInterval};
        `REG_STATUS:    rdata <= {14'h0000, !suppress,
                                  overvoltageLatchedFlag};
        `REG_LED1_ON:   rdata <= {7'h00, ledOnVoltageResult1};
        `REG_LED1:      rdata <= {7'h00, ledStringVoltageResult1};
        `REG_LED2_ON:   rdata <= {7'h00, ledOnVoltageResult2};
        `REG_LED2:      rdata <= {7'h00, ledStringVoltageResult2};
        `REG_BOOST_ADC: rdata <= {7'h00, withParity(boostOutputVoltage)};
        `REG_IRQ_STAT:  rdata <= {12'h000, irqStatus};
        `REG_IRQ_MASK:  rdata <= {12'h000, irqMask};
        default:        rdata <= 16'h0000;
      endcase
    end
    else
      rdata <= 16'h0000;
  end

endmodule

`default_nettype wire

/* overvoltage_latched_flag_chk.sv */
// Purpose: port checks of the boost overvoltage block
// Assumes: shadow copies of the config registers follow port writes
// Notes:   bound to every instance of the design
`timescale 1ns/1ps
`include "overvoltage_latched_flag_consts.vh"
`default_nettype none
module overvoltage_latched_flag_chk
#(
  parameter LOW_FB_GUARD = 1
)
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [15:0] rdata,
  input wire logic        adcValid,
  input wire logic [1:0]  adcSel,
  input wire logic [7:0]  adcCode,
  input wire logic        adcSeqDone,
  input wire logic [1:0]  ledChannelControlInput,
  input wire logic        boostFeedbackLow,
  input wire logic        pwmRaw,
  input wire logic        gateOut,
  input wire logic [1:0]  measReq,
  input wire logic        irq
);
  // ****************
  // shadow state
  // ****************
  logic       en;
  logic       sup;
  logic [6:0] tgt;
  logic [5:0] cfg;
  logic [8:0] fint;
  logic [3:0] msk;
  logic [7:0] code;
  wire [13:0] prod = tgt * 14'd98;
  wire [9:0]  sdLvl = 10'd40 + prod[13:6] + {cfg[2:0], 2'b00};
  wire [9:0]  reLvl = sdLvl - {cfg[5:4], 2'b00};
  wire        low = (LOW_FB_GUARD != 0) && boostFeedbackLow;
  wire        trip = ({2'b00, code} > sdLvl) || low;
  // suppression kept apart from the flag: only reactivation clears it
  always @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      en <= 1'b0;
      sup <= 1'b0;
      tgt <= 7'h00;
      cfg <= 6'h00;
      fint <= 9'h000;
      msk <= 4'h0;
      code <= 8'h00;
    end
    else
    begin
      if (wrStb && addr == `REG_CTRL) en <= wdata[0];
      if (wrStb && addr == `REG_TARGET) tgt <= wdata[6:0];
      if (wrStb && addr == `REG_OVCFG) cfg <= wdata[5:0];
      if (wrStb && addr == `REG_FORCED) fint <= wdata[8:0];
      if (wrStb && addr == `REG_IRQ_MASK) msk <= wdata[3:0];
      if (adcValid && adcSel == `ADC_BOOST) code <= adcCode;
      if (trip) sup <= 1'b1;
      else if ({2'b00, code} < reLvl && !low) sup <= 1'b0;
    end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_gate_needs_en: assert property (!en && !$past(en) |-> !gateOut)
    else $error("gate driven while disabled");
  a_trip_gate_low: assert property (trip |-> ##2 !gateOut)
    else $error("gate still on after trip");
  a_suppress_holds: assert property (sup && $past(sup) |-> !gateOut)
    else $error("gate on while suppressed");
  a_gate_tracks_pwm: assert property (gateOut |-> $past(pwmRaw))
    else $error("gate on without pwm");
  a_read_one_cycle: assert property (!$past(rdStb) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_running_flag: assert property ($past(rdStb) && $past(addr) == `REG_STATUS
    |-> rdata[1] == !$past(sup) && rdata[15:2] == 14'h0000)
    else $error("running flag wrong");
  a_irq_needs_mask: assert property (msk == 4'h0 |-> !irq)
    else $error("irq with all sources masked");
  a_measreq_pulse: assert property (measReq[0] |=> !measReq[0])
    else $error("request longer than one cycle");
  a_forced_off: assert property ($past(fint) == 9'h000
    && ledChannelControlInput == $past(ledChannelControlInput)
    && ledChannelControlInput == $past(ledChannelControlInput, 2) |-> measReq == 2'h0)
    else $error("forced request with zero interval");
endmodule
bind boost_setpoint_ov_protect overvoltage_latched_flag_chk #(.LOW_FB_GUARD(LOW_FB_GUARD)) chk
(
  .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wrStb(wrStb),
  .rdStb(rdStb), .rdata(rdata), .adcValid(adcValid), .adcSel(adcSel),
  .adcCode(adcCode), .adcSeqDone(adcSeqDone),
  .ledChannelControlInput(ledChannelControlInput),
  .boostFeedbackLow(boostFeedbackLow), .pwmRaw(pwmRaw), .gateOut(gateOut),
  .measReq(measReq), .irq(irq)
);
`default_nettype wire

/* boost_stage_model.sv */
// Purpose: converter stage and ADC sequencer seen from the block
// Assumes: samples are single-cycle pulses on mclk
// Notes:   pwm runs free with a period of four cycles
`timescale 1ns/1ps
`default_nettype none
module boost_stage_model
(
  input  wire logic      mclk,
  output var logic       adcValid,
  output var logic [1:0] adcSel,
  output var logic [7:0] adcCode,
  output var logic       adcSeqDone,
  output var logic       pwmRaw
);
  // ****************
  // stimulus
  // ****************
  logic [1:0] ph;
  initial
  begin
    {adcValid, adcSel, adcCode, adcSeqDone, pwmRaw, ph} = 15'h0000;
  end
  // free-running loop pwm
  always @(posedge mclk)
  begin
    ph <= ph + 2'h1;
    pwmRaw <= ph[1];
  end
  // code line shows the inverse once released, so stale data never matches
  task sample(input [1:0] s, input [7:0] c);
  begin
    @(posedge mclk);
    adcValid <= 1'b1;
    adcSel <= s;
    adcCode <= c;
    @(posedge mclk);
    adcValid <= 1'b0;
    adcCode <= ~c;
  end
  endtask
  task seq_done;
  begin
    @(posedge mclk);
    adcSeqDone <= 1'b1;
    @(posedge mclk);
    adcSeqDone <= 1'b0;
  end
  endtask
endmodule
`default_nettype wire

/* boost_setpoint_ov_protect_tb.sv */
// Purpose: self-checking bench of the boost overvoltage block
// Assumes: 50 MHz mclk, read data one cycle after the strobe
// Notes:   ceiling of 3000 cycles, the run needs well under 1000
`timescale 1ns/1ps
`include "overvoltage_latched_flag_consts.vh"
`default_nettype none
module boost_setpoint_ov_protect_tb;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wrStb = 1'b0;
  logic        rdStb = 1'b0;
  logic [1:0]  ctrl = 2'h3;
  logic        fbLow = 1'b0;
  logic        gateSeen = 1'b0;
  logic [7:0]  c;
  wire  [15:0] rdata;
  wire  [7:0]  adcCode;
  wire  [1:0]  adcSel;
  wire  [1:0]  measReq;
  wire         adcValid, adcSeqDone, pwmRaw, gateOut, irq;
  integer      mismatches = 0, n_checks = 0, cycles = 0, pulses = 0, pulses2 = 0, i;
  boost_setpoint_ov_protect dut
  (
    .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wrStb(wrStb),
    .rdStb(rdStb), .rdata(rdata), .adcValid(adcValid), .adcSel(adcSel),
    .adcCode(adcCode), .adcSeqDone(adcSeqDone), .ledChannelControlInput(ctrl),
    .boostFeedbackLow(fbLow), .pwmRaw(pwmRaw), .gateOut(gateOut),
    .measReq(measReq), .irq(irq)
  );
  boost_stage_model stage
  (
    .mclk(mclk), .adcValid(adcValid), .adcSel(adcSel), .adcCode(adcCode),
    .adcSeqDone(adcSeqDone), .pwmRaw(pwmRaw)
  );
  // ****************
  // clock, observers, helpers
  // ****************
  always #10 mclk = ~mclk;
  // observed mid-cycle so edge updates have landed
  always @(negedge mclk)
  begin
    cycles = cycles + 1;
    if (gateOut === 1'b1) gateSeen = 1'b1;
    if (measReq[0] === 1'b1) pulses = pulses + 1;
    if (measReq[1] === 1'b1) pulses2 = pulses2 + 1;
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
  begin
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
    @(negedge mclk);
  end
  endtask
  task rd(input [3:0] a, input [15:0] exp);
  begin
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(negedge mclk);
    chk(rdata, exp);
  end
  endtask
  // threshold walk: edge of shutdown, trip, edge of reactivation, recovery
  task ovcase(input [6:0] t, input [2:0] m, input [1:0] h);
    integer sd, re;
  begin
    sd = 40 + ((t * 98) >> 6) + 4 * m;
    re = sd - 4 * h;
    wr(`REG_TARGET, {9'h000, t});
    wr(`REG_OVCFG, {10'h000, h, 1'b0, m});
    stage.sample(`ADC_BOOST, sd[7:0]);
    rd(`REG_STATUS, 16'h0002);
    stage.sample(`ADC_BOOST, sd[7:0] + 8'h01);
    rd(`REG_STATUS, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    chk({15'h0000, gateOut}, 16'h0000);
    stage.sample(`ADC_BOOST, re[7:0]);
    rd(`REG_STATUS, 16'h0001);
    stage.sample(`ADC_BOOST, re[7:0] - 8'h01);
    rd(`REG_STATUS, 16'h0003);
    rd(`REG_STATUS, 16'h0002);
    wr(`REG_IRQ_STAT, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
  end
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    rd(`REG_STATUS, 16'h0003);
    rd(`REG_STATUS, 16'h0002);
    rd(`REG_TARGET, 16'h0000);
    rd(`REG_CTRL, 16'h0000);
    rd(`REG_LED1, 16'h0100);
    rd(4'hf, 16'h0000);
    wr(`REG_IRQ_MASK, 16'h000f);
    ovcase(7'h00, 3'h1, 2'h1);
    chk({15'h0000, gateSeen}, 16'h0000);
    wr(`REG_CTRL, 16'h0001);
    repeat (12) @(posedge mclk);
    chk({15'h0000, gateSeen}, 16'h0001);
    ovcase(7'h7f, 3'h4, 2'h3);
    @(posedge mclk);
    fbLow <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`REG_STATUS, 16'h0001);
    @(posedge mclk);
    fbLow <= 1'b0;
    rd(`REG_STATUS, 16'h0003);
    // parity alternates across codes 00, 01, 03, 07 and their inverses
    for (i = 0; i < 4; i = i + 1)
    begin
      c = (8'h01 << i) - 8'h01;
      stage.sample(`ADC_LED1, c);
      rd(`REG_LED1_ON, {7'h00, ~^c, c});
      rd(`REG_LED1, {7'h00, ~^c, c});
      stage.sample(`ADC_LED2, ~c);
      rd(`REG_LED2_ON, {7'h00, ~^c, ~c});
      rd(`REG_LED2, {7'h00, ~^c, ~c});
    end
    rd(`REG_IRQ_STAT, 16'h0007);
    wr(`REG_IRQ_MASK, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr(`REG_IRQ_MASK, 16'h0004);
    chk({15'h0000, irq}, 16'h0001);
    wr(`REG_IRQ_STAT, 16'h000f);
    chk({15'h0000, irq}, 16'h0000);
    wr(`REG_FORCED, 16'h0002);
    pulses = 0;
    pulses2 = 0;
    repeat (4) stage.seq_done;
    repeat (3) @(posedge mclk);
    chk(pulses[15:0], 16'h0002);
    chk(pulses2[15:0], 16'h0002);
    rd(`REG_IRQ_STAT, 16'h0008);
    wr(`REG_FORCED, 16'h0000);
    pulses = 0;
    pulses2 = 0;
    repeat (3) stage.seq_done;
    repeat (3) @(posedge mclk);
    chk(pulses[15:0], 16'h0000);
    chk(pulses2[15:0], 16'h0000);
    // falling control requests a read; the on-voltage keeps its lit value
    @(posedge mclk);
    ctrl <= 2'h2;
    repeat (3) @(posedge mclk);
    chk(pulses[15:0], 16'h0001);
    chk(pulses2[15:0], 16'h0000);
    stage.sample(`ADC_LED1, 8'h5a);
    rd(`REG_LED1_ON, 16'h0007);
    rd(`REG_LED1, {7'h00, ~^8'h5a, 8'h5a});
    @(posedge mclk);
    ctrl <= 2'h3;
    // a reset in mid-run brings back the power-up state
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    rd(`REG_CTRL, 16'h0000);
    rd(`REG_TARGET, 16'h0000);
    rd(`REG_STATUS, 16'h0003);
    chk({15'h0000, gateOut}, 16'h0000);
    report_and_stop;
  end
endmodule
`default_nettype wire
